// ==== bench/cdr_loop_and_output_swing_test.sv ====
// Self-checking bench for the CDR control block: swing register, input
// stage, slice source, acquisition, phase loops and elastic buffer.
// Assumes the far-side model in cdr_nrz_src; one 125 MHz clock.
`timescale 1ns/10ps
module cdr_loop_and_output_swing_test;
  import cdr_pkg::*;
  logic clk_i, rst_i, we, re, fvld, e_up, pop, s_up;
  logic [7:0] addr, wdat, rdat;
  logic signed [15:0] ppm;
  logic [1:0] mode, sel;
  logic dsmp, esmp, rtm, rdo, ovf, lock_lost_flag;
  logic [9:0] digital_controlled_oscillator, d0;
  logic [5:0] clock_phase_shifter, p0;
  logic [2:0] div;
  logic [3:0] eqb, dsw, csw;
  logic [6:0] slc;
  int failures, n_compared;
  cdr_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .reg_we_i(we), .reg_re_i(re),
    .reg_addr_i(addr), .reg_wdata_i(wdat), .reg_rdata_o(rdat), .data_smp_i(dsmp),
    .edge_smp_i(esmp), .freq_vld_i(fvld), .freq_ppm_i(ppm), .slice_trim_i(7'h31),
    .slice_up_i(s_up), .slice_dn_i(1'b0), .eq_up_i(e_up), .eq_dn_i(1'b0),
    .retime_i(rtm), .retime_data_o(rdo), .eb_ovf_o(ovf),
    .digital_controlled_oscillator_o(digital_controlled_oscillator), .clock_phase_shifter_o(clock_phase_shifter),
    .div_log2_o(div), .lock_lost_flag_o(lock_lost_flag), .input_sel_o(sel), .eq_boost_o(eqb),
    .slice_o(slc), .data_swing_o(dsw), .clk_swing_o(csw));
  cdr_nrz_src i_src (.clk_i(clk_i), .mode_i(mode), .pop_i(pop), .data_o(dsmp),
    .edge_o(esmp), .retime_o(rtm));
  // Free-running 8 ns clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk
  task automatic tick;
    @(posedge clk_i);
    #1;
  endtask : tick
  // Each access leaves an idle cycle so strobes never toggle twice at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    we = 1'b1; addr = a; wdat = d;
    tick;
    we = 1'b0;
    tick;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    re = 1'b1; addr = a;
    tick;
    re = 1'b0;
    chk(rdat, exp, "read data");
    tick;
  endtask : rd
  task automatic freq(input logic signed [15:0] p);
    fvld = 1'b1; ppm = p;
    tick;
    fvld = 1'b0;
    tick;
  endtask : freq
  // Bounded wait for the lock flag; running out ends the run
  task automatic wait_lol(input logic exp);
    int i;
    for (i = 0; i < 8 && lock_lost_flag !== exp; i++) tick;
    chk(lock_lost_flag, exp, "lock flag");
    if (lock_lost_flag !== exp) stop_test;
  endtask : wait_lol
  task automatic t_reset;
    chk(dsw, SWING_RST, "data swing reset");
    chk(csw, SWING_RST, "clock swing reset");
    chk(lock_lost_flag, 1'b1, "lock flag reset");
    chk(sel, SEL_LIMAMP, "input stage reset");
    rd(ADDR_SWING, 8'hcc);
  endtask : t_reset
  task automatic t_swing;
    int i;
    wr(ADDR_SWING, 8'h35);
    chk(dsw, 4'hc, "invalid data code kept");
    chk(csw, 4'h5, "clock code");
    wr(ADDR_SWING, 8'h4f);
    chk({dsw, csw}, 8'h4f, "both codes");
    // Every invalid code on both nibbles leaves the previous setting in place
    for (i = 0; i < 4; i++) begin
      wr(ADDR_SWING, {i[3:0], i[3:0]});
      chk({dsw, csw}, 8'h4f, "invalid codes kept");
    end
    rd(ADDR_SWING, 8'h4f);
    rd(8'h00, 8'h00);
  endtask : t_swing
  task automatic t_sel;
    int s;
    for (s = 0; s < 3; s++) begin
      wr(ADDR_INSTAGE, {1'b0, s[1:0], 5'h00});
      chk(sel, s[1:0], "input stage");
    end
    wr(ADDR_INSTAGE, 8'h60);
    chk(sel, SEL_BUF, "undefined stage refused");
    wr(ADDR_INSTAGE, 8'h00);
  endtask : t_sel
  task automatic t_slice;
    chk(slc, 7'h31, "trim slice");
    wr(ADDR_SLICE, 8'h22);
    chk(slc, 7'h22, "user slice");
    wr(ADDR_DPLL, 8'h04);
    chk(slc, SLICE_MID, "adaptive slice");
    s_up = 1'b1;
    tick;
    s_up = 1'b0;
    tick;
    chk(slc, 7'h41, "adaptive slice step");
    wr(ADDR_DPLL, 8'h00);
    wr(ADDR_SLICE, 8'h00);
    chk(slc, 7'h31, "back to trim");
  endtask : t_slice
  task automatic t_acq;
    freq(16'sd500);
    chk(div, 3'h1, "division doubled");
    freq(16'sd100);
    wait_lol(1'b0);
    rd(ADDR_STATUS, 8'h02);
    freq(16'sd2000);
    chk({lock_lost_flag, div, digital_controlled_oscillator}, {1'b1, 3'h0, 10'h000}, "restart");
    freq(-16'sd300);
    chk(digital_controlled_oscillator, 10'h001, "fine step up");
    freq(16'sd0);
    wait_lol(1'b0);
    freq(-16'sd300);
    chk(digital_controlled_oscillator, 10'h001, "frequency loop off");
  endtask : t_acq
  // Two captures one cycle apart while the stream runs
  task automatic step(input logic [5:0] dp, input logic [9:0] dd, input string msg);
    p0 = clock_phase_shifter; d0 = digital_controlled_oscillator;
    tick;
    chk(clock_phase_shifter, 6'(p0 + dp), msg);
    chk(digital_controlled_oscillator, 10'(d0 + dd), msg);
  endtask : step
  task automatic t_phase;
    mode = 2'h1; pop = 1'b1;
    repeat (20) tick;
    step(6'h3f, 10'h001, "late decision");
    p0 = {5'h00, rdo};
    tick;
    chk(rdo, 1'(~p0[0]), "retimed bit order");
    chk(ovf, 1'b0, "no overflow");
    mode = 2'h2;
    repeat (7) tick;
    step(6'h01, 10'h3ff, "early decision");
    mode = 2'h0; pop = 1'b0;
    repeat (6) tick;
    step(6'h00, 10'h000, "no transition");
  endtask : t_phase
  task automatic t_sat;
    freq(16'sd2000);
    repeat (70) freq(-16'sd5000);
    chk(digital_controlled_oscillator, 10'h3ff, "oscillator saturates");
    // Equalizer stage selected, adaptation on, boost 5
    wr(ADDR_INSTAGE, 8'h35);
    e_up = 1'b1;
    tick;
    e_up = 1'b0;
    tick;
    chk(eqb, 4'h6, "adaptive boost fast");
    freq(16'sd2000);
    wr(ADDR_INSTAGE, 8'h35);
    e_up = 1'b1;
    tick;
    e_up = 1'b0;
    tick;
    chk(eqb, 4'h5, "manual boost slow");
  endtask : t_sat
  // Host sets reference mode and ratio; a restart then loads that ratio
  task automatic t_ref;
    wr(ADDR_ACQ, 8'h07);
    freq(16'sd0);
    freq(16'sd2000);
    chk(div, 3'h3, "reference ratio loaded");
    freq(16'sd500);
    chk(div, 3'h3, "ratio held in reference mode");
    rd(ADDR_ACQ, 8'h07);
    wr(ADDR_ACQ, 8'h00);
  endtask : t_ref
  task automatic t_ovf;
    mode = 2'h1;
    repeat (50) tick;
    chk(ovf, 1'b1, "buffer overflow");
    mode = 2'h0;
  endtask : t_ovf
  // Main sequence
  initial begin
    failures = 0; n_compared = 0;
    // Downstream strobe runs from the start: the overflow flag is sticky
    rst_i = 1'b1; we = 1'b0; re = 1'b0; fvld = 1'b0; e_up = 1'b0; pop = 1'b1;
    s_up = 1'b0;
    addr = 8'h00; wdat = 8'h00; ppm = 16'sd0; mode = 2'h0;
    repeat (3) tick;
    rst_i = 1'b0;
    tick;
    t_reset;
    t_swing;
    t_sel;
    t_slice;
    t_acq;
    t_phase;
    t_sat;
    t_ref;
    t_ovf;
    stop_test;
  end
endmodule : cdr_loop_and_output_swing_test

// ==== bench/cdr_nrz_src.sv ====
// Far-side model: serial data source feeding the sample pins, plus the
// downstream receiver strobing retimed bits out of the elastic buffer.
// Assumes the bench picks the mode; pins change 1 ns after each edge.
`timescale 1ns/10ps
module cdr_nrz_src (
  input  wire logic       clk_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       pop_i,
  output logic            data_o,
  output logic            edge_o,
  output logic            retime_o
);
  // Mode 0 holds the line, 1 gives late edges, 2 early ones
  initial begin
    data_o   = 1'b0;
    edge_o   = 1'b0;
    retime_o = 1'b0;
    forever begin
      @(posedge clk_i);
      #1;
      retime_o = pop_i;
      if (mode_i == 2'h0) begin
        edge_o = data_o; // No transition, nothing to decide
      end else begin
        edge_o = (mode_i == 2'h1) ? ~data_o : data_o;
        data_o = ~data_o;
      end
    end
  end
endmodule : cdr_nrz_src

// ==== pkg/cdr_pkg.sv ====
// Constants, register map and state types for the CDR control block.
// Assumes a single 125 MHz clock domain and an 8-bit register port
// driven by the serial control interface outside this block.
package cdr_pkg;
  // Clock rate, for reference by derived counts
  localparam int unsigned CLK_MHZ = 125;

  // Register addresses
  localparam logic [7:0] ADDR_DPLL    = 8'h13;
  localparam logic [7:0] ADDR_SLICE   = 8'h15;
  localparam logic [7:0] ADDR_INSTAGE = 8'h16;
  localparam logic [7:0] ADDR_SWING   = 8'h1f;
  localparam logic [7:0] ADDR_ACQ     = 8'h20;
  localparam logic [7:0] ADDR_STATUS  = 8'h21;

  // Field positions
  localparam int unsigned DPLL_ASLICE_BIT = 2;
  localparam int unsigned IN_SEL_LSB      = 5;
  localparam int unsigned IN_AEQ_BIT      = 4;
  localparam int unsigned SWING_DATA_LSB  = 4;
  localparam int unsigned ACQ_REF_BIT     = 0;
  localparam int unsigned ACQ_DIV_LSB     = 1;

  // Reset values and codes
  localparam logic [3:0] SWING_RST      = 4'hc;
  localparam logic [3:0] SWING_MIN_OK   = 4'h4;
  localparam logic [1:0] SEL_LIMAMP     = 2'h0;
  localparam logic [1:0] SEL_EQ         = 2'h1;
  localparam logic [1:0] SEL_BUF        = 2'h2;
  localparam logic [1:0] SEL_UNDEF      = 2'h3;
  localparam logic [6:0] SLICE_OFF      = 7'h00;
  localparam logic [6:0] SLICE_MID      = 7'h40;
  localparam logic [3:0] EQ_BOOST_RST   = 4'h0;

  // Frequency acquisition thresholds in ppm
  localparam logic [15:0] LOCK_PPM      = 16'd250;
  localparam logic [15:0] UNLOCK_PPM    = 16'd1000;
  localparam logic [15:0] COARSE_PPM    = 16'd4000;

  // Acquisition states, one-hot
  typedef enum logic [2:0] {
    CDR_ACQ_RST  = 3'b001,
    CDR_ACQ_MEAS = 3'b010,
    CDR_TRACK    = 3'b100
  } cdr_acq_e;
endpackage : cdr_pkg

// ==== rtl/cdr_elastic.sv ====
// Elastic buffer between the decision clock and the retiming strobe.
// Assumes both sides run on the same clock; writes and reads are strobes.
`timescale 1ns/10ps
module cdr_elastic
  import cdr_pkg::*;
#(
  parameter int unsigned W     = 1,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         wr_i,
  input  wire logic [W-1:0] wdata_i,
  input  wire logic         rd_i,
  output logic     [W-1:0]  rdata_o,
  output logic              full_o,
  output logic              empty_o,
  output logic              ovf_o
);
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW:0]             wp;
    logic [AW:0]             rp;
    logic [W-1:0]            rdata;
    logic                    ovf;
  } cdr_eb_s;

  cdr_eb_s q_ff;
  cdr_eb_s nxt_q;
  logic    full;
  logic    empty;

  // Wrap bit tells full from empty
  assign full    = (q_ff.wp[AW] != q_ff.rp[AW]) && (q_ff.wp[AW-1:0] == q_ff.rp[AW-1:0]);
  assign empty   = (q_ff.wp == q_ff.rp);
  assign full_o  = full;
  assign empty_o = empty;
  assign rdata_o = q_ff.rdata;
  assign ovf_o   = q_ff.ovf;

  // Mismatch beyond the depth drops the bit and flags it
  always_comb begin
    nxt_q = q_ff;
    if (wr_i && !full) begin
      nxt_q.mem[q_ff.wp[AW-1:0]] = wdata_i;
      nxt_q.wp = q_ff.wp + 1'b1;
    end
    if (wr_i && full) begin
      nxt_q.ovf = 1'b1;
    end
    if (rd_i && !empty) begin
      nxt_q.rdata = q_ff.mem[q_ff.rp[AW-1:0]];
      nxt_q.rp    = q_ff.rp + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  a_eb_no_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
    full && wr_i && !rd_i |=> $stable(q_ff.wp) && ovf_o)
    else $error("elastic buffer pointer moved while full");
endmodule : cdr_elastic

// ==== rtl/cdr_top.sv ====
// CDR digital control: downsampler, binary phase detector, phase and
// frequency integrators, acquisition machine, front-end and swing settings.
// Assumes sample bits arrive from the fast sampler as pin-level inputs and
// the lock detector supplies a signed ppm difference on this clock.
`timescale 1ns/10ps
// Functional notes
// - Data swing upper nibble, reset 0xC
// - Clock swing lower nibble, reset 0xC
// - Exactly one input stage selected
// - EQ adapts only when enabled and fast
// - Slice from trim, user or adaptive
// - Loop covers full data rate range
// - Downsampler feeds early/late phase detector
// - Phase integrator steers the phase shifter
// - Frequency integrator sets oscillator word
// - Lag raises frequency in tracking, shortens delay
// - Oscillator word saturates at limits
// - Phase shifter word wraps freely
// - Elastic buffer absorbs 32 UI
// - Frequency loop sets oscillator and ratio
// - Acquire within 250 ppm, then track
// - Beyond 1000 ppm: lock lost, restart
// - Once locked, frequency loop switched off
module cdr_top
  import cdr_pkg::*;
#(
  parameter int unsigned DCO_W    = 10,
  parameter int unsigned PSH_W    = 6,
  parameter int unsigned DIV_W    = 3,
  parameter int unsigned EB_DEPTH = 32,
  parameter logic [9:0]  DCO_STEP = 10'd16,
  parameter logic [9:0]  FAST_DCO = 10'd512
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  input  wire logic [7:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              data_smp_i,
  input  wire logic              edge_smp_i,
  input  wire logic              freq_vld_i,
  input  wire logic signed [15:0] freq_ppm_i,
  input  wire logic [6:0]        slice_trim_i,
  input  wire logic              slice_up_i,
  input  wire logic              slice_dn_i,
  input  wire logic              eq_up_i,
  input  wire logic              eq_dn_i,
  input  wire logic              retime_i,
  output logic                   retime_data_o,
  output logic                   eb_ovf_o,
  output logic [DCO_W-1:0]       digital_controlled_oscillator_o,
  output logic [PSH_W-1:0]       clock_phase_shifter_o,
  output logic [DIV_W-1:0]       div_log2_o,
  output logic                   lock_lost_flag_o,
  output logic [1:0]             input_sel_o,
  output logic [3:0]             eq_boost_o,
  output logic [6:0]             slice_o,
  output logic [3:0]             data_swing_o,
  output logic [3:0]             clk_swing_o
);
  typedef struct packed {
    logic [1:0]       smp_meta;
    logic [1:0]       smp_sync;
    logic             prev_data;
    logic [7:0]       dec_cnt;
    cdr_acq_e         st;
    logic [DCO_W-1:0] digital_controlled_oscillator;
    logic [PSH_W-1:0] clock_phase_shifter;
    logic [DIV_W-1:0] div;
    logic             lock_lost_flag;
    logic [7:0]       output_amplitude_control;
    logic             adapt_slice;
    logic [6:0]       slice_usr;
    logic [6:0]       slice_adp;
    logic [1:0]       in_sel;
    logic             adapt_eq;
    logic [3:0]       eq_man;
    logic [3:0]       eq_adp;
    logic             ref_mode;
    logic [DIV_W-1:0] ref_div;
    logic [7:0]       rdata;
  } cdr_top_s;

  cdr_top_s         q_ff;
  cdr_top_s         nxt_q;
  logic             take;
  logic             trans;
  logic             late;
  logic             early;
  logic [15:0]      ppm_abs;
  logic             rate_fast;
  logic [7:0]       dec_last;
  logic [DCO_W-1:0] dco_max;
  logic [DCO_W-1:0] dco_step;
  logic             wr_swing;

  // Downsampler picks one decision every 2^div samples
  assign dec_last = 8'((9'd1 << q_ff.div) - 9'd1);
  assign take     = (q_ff.dec_cnt >= dec_last);
  // Early/late decision from data and edge samples
  assign trans    = take && (q_ff.smp_sync[1] != q_ff.prev_data);
  assign late     = trans && (q_ff.smp_sync[0] == q_ff.smp_sync[1]);
  assign early    = trans && !late;
  assign ppm_abs  = freq_ppm_i[15] ? 16'(-freq_ppm_i) : 16'(freq_ppm_i);
  assign dco_max  = '1;
  assign dco_step = DCO_W'(DCO_STEP);
  // Adaptive EQ only above 5.5 Gbps: top octave, upper half of tuning
  assign rate_fast = (q_ff.div == '0) && (q_ff.digital_controlled_oscillator >= DCO_W'(FAST_DCO));
  assign wr_swing  = reg_we_i && (reg_addr_i == ADDR_SWING);

  // Register writes, loops and acquisition in one next-state process
  always_comb begin
    nxt_q = q_ff;
    // Data sample in the upper bit, edge sample in the lower one
    nxt_q.smp_meta = {data_smp_i, edge_smp_i};
    nxt_q.smp_sync = q_ff.smp_meta;
    nxt_q.dec_cnt  = take ? 8'h00 : q_ff.dec_cnt + 8'h01;
    if (take) begin
      nxt_q.prev_data = q_ff.smp_sync[1];
    end
    // Register port writes
    if (reg_we_i) begin
      unique case (reg_addr_i)
        ADDR_DPLL: nxt_q.adapt_slice = reg_wdata_i[DPLL_ASLICE_BIT];
        ADDR_SLICE: nxt_q.slice_usr = reg_wdata_i[6:0];
        ADDR_INSTAGE: begin
          if (reg_wdata_i[IN_SEL_LSB +: 2] != SEL_UNDEF) begin
            nxt_q.in_sel = reg_wdata_i[IN_SEL_LSB +: 2];
          end
          nxt_q.adapt_eq = reg_wdata_i[IN_AEQ_BIT];
          nxt_q.eq_man   = reg_wdata_i[3:0];
          nxt_q.eq_adp   = reg_wdata_i[3:0];
        end
        ADDR_SWING: begin
          if (reg_wdata_i[SWING_DATA_LSB +: 4] >= SWING_MIN_OK) begin
            nxt_q.output_amplitude_control[SWING_DATA_LSB +: 4] =
              reg_wdata_i[SWING_DATA_LSB +: 4];
          end
          if (reg_wdata_i[3:0] >= SWING_MIN_OK) begin
            nxt_q.output_amplitude_control[3:0] = reg_wdata_i[3:0];
          end
        end
        ADDR_ACQ: begin
          nxt_q.ref_mode = reg_wdata_i[ACQ_REF_BIT];
          nxt_q.ref_div  = reg_wdata_i[ACQ_DIV_LSB +: DIV_W];
        end
        default: ;
      endcase
    end
    // Read data captured on the read strobe
    if (reg_re_i) begin
      unique case (reg_addr_i)
        ADDR_DPLL:    nxt_q.rdata = {5'h00, q_ff.adapt_slice, 2'h0};
        ADDR_SLICE:   nxt_q.rdata = {1'b0, q_ff.slice_usr};
        ADDR_INSTAGE: nxt_q.rdata = {1'b0, q_ff.in_sel, q_ff.adapt_eq, q_ff.eq_man};
        ADDR_SWING:   nxt_q.rdata = q_ff.output_amplitude_control;
        ADDR_ACQ:     nxt_q.rdata = 8'({q_ff.ref_div, q_ff.ref_mode});
        ADDR_STATUS:  nxt_q.rdata = 8'({q_ff.div, q_ff.lock_lost_flag});
        default:      nxt_q.rdata = 8'h00;
      endcase
    end
    // Adaptive slice walks toward the widest eye
    if (q_ff.adapt_slice) begin
      if (slice_up_i && (q_ff.slice_adp != 7'h7f)) begin
        nxt_q.slice_adp = q_ff.slice_adp + 7'h01;
      end else if (slice_dn_i && (q_ff.slice_adp != 7'h01)) begin
        nxt_q.slice_adp = q_ff.slice_adp - 7'h01;
      end
    end
    // EQ adaptation gated by enable and data rate
    if (q_ff.adapt_eq && rate_fast && (q_ff.in_sel == SEL_EQ)) begin
      if (eq_up_i && (q_ff.eq_adp != 4'hf)) begin
        nxt_q.eq_adp = q_ff.eq_adp + 4'h1;
      end else if (eq_dn_i && (q_ff.eq_adp != 4'h0)) begin
        nxt_q.eq_adp = q_ff.eq_adp - 4'h1;
      end
    end
    // Phase shifter always tracks; free wrap avoids range limits
    if (late) begin
      nxt_q.clock_phase_shifter = q_ff.clock_phase_shifter - 1'b1;
    end else if (early) begin
      nxt_q.clock_phase_shifter = q_ff.clock_phase_shifter + 1'b1;
    end
    // Acquisition and frequency tracking
    unique case (q_ff.st)
      CDR_ACQ_RST: begin
        nxt_q.lock_lost_flag = 1'b1;
        nxt_q.digital_controlled_oscillator = '0;
        nxt_q.div = q_ff.ref_mode ? q_ff.ref_div : '0;
        nxt_q.st  = CDR_ACQ_MEAS;
      end
      CDR_ACQ_MEAS: begin
        if (freq_vld_i) begin
          if (ppm_abs <= LOCK_PPM) begin
            nxt_q.lock_lost_flag = 1'b0;
            nxt_q.st  = CDR_TRACK;
          end else if (!freq_ppm_i[15]) begin
            // Sampling too fast: next octave down, or lower word in ref mode or at the last octave
            if (!q_ff.ref_mode && (q_ff.div != '1)) begin
              nxt_q.div = q_ff.div + 1'b1;
              nxt_q.digital_controlled_oscillator = '0;
            end else if (q_ff.digital_controlled_oscillator != '0) begin
              nxt_q.digital_controlled_oscillator = q_ff.digital_controlled_oscillator - 1'b1;
            end
          end else begin
            // Big steps first, single steps near the target
            if (ppm_abs > COARSE_PPM) begin
              nxt_q.digital_controlled_oscillator = (q_ff.digital_controlled_oscillator > dco_max - dco_step) ? dco_max
                                                          : q_ff.digital_controlled_oscillator + dco_step;
            end else if (q_ff.digital_controlled_oscillator != dco_max) begin
              nxt_q.digital_controlled_oscillator = q_ff.digital_controlled_oscillator + 1'b1;
            end
          end
        end
      end
      CDR_TRACK: begin
        // Frequency loop idle; only the phase decisions move the word
        if (late && (q_ff.digital_controlled_oscillator != dco_max)) begin
          nxt_q.digital_controlled_oscillator = q_ff.digital_controlled_oscillator + 1'b1;
        end else if (early && (q_ff.digital_controlled_oscillator != '0)) begin
          nxt_q.digital_controlled_oscillator = q_ff.digital_controlled_oscillator - 1'b1;
        end
        if (freq_vld_i && (ppm_abs > UNLOCK_PPM)) begin
          nxt_q.lock_lost_flag = 1'b1;
          nxt_q.st  = CDR_ACQ_RST;
        end
      end
      default: nxt_q.st = CDR_ACQ_RST;
    endcase
  end

  // Single state register for the block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_ff <= '0;
      q_ff.st <= CDR_ACQ_RST;
      q_ff.lock_lost_flag <= 1'b1;
      q_ff.output_amplitude_control <= {SWING_RST, SWING_RST};
      q_ff.in_sel <= SEL_LIMAMP;
      q_ff.eq_man <= EQ_BOOST_RST;
      q_ff.eq_adp <= EQ_BOOST_RST;
      q_ff.slice_adp <= SLICE_MID;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Retimed decisions cross to the output strobe
  cdr_elastic #(
    .W     (1),
    .DEPTH (EB_DEPTH)
  ) u_elastic (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .wr_i    (take),
    .wdata_i (q_ff.smp_sync[1]),
    .rd_i    (retime_i),
    .rdata_o (retime_data_o),
    .full_o  (),
    .empty_o (),
    .ovf_o   (eb_ovf_o)
  );

  // Output mapping; slice source: off code means factory trim
  assign reg_rdata_o                     = q_ff.rdata;
  assign digital_controlled_oscillator_o = q_ff.digital_controlled_oscillator;
  assign clock_phase_shifter_o           = q_ff.clock_phase_shifter;
  assign div_log2_o                      = q_ff.div;
  assign lock_lost_flag_o                = q_ff.lock_lost_flag;
  assign input_sel_o                     = q_ff.in_sel;
  assign eq_boost_o  = (q_ff.adapt_eq && rate_fast) ? q_ff.eq_adp : q_ff.eq_man;
  assign slice_o     = q_ff.adapt_slice ? q_ff.slice_adp :
                       (q_ff.slice_usr == SLICE_OFF) ? slice_trim_i : q_ff.slice_usr;
  assign data_swing_o = q_ff.output_amplitude_control[SWING_DATA_LSB +: 4];
  assign clk_swing_o  = q_ff.output_amplitude_control[3:0];

  // Lock loss: flag, then oscillator word back at the bottom
  sequence s_unlock;
    (q_ff.st == CDR_TRACK) && freq_vld_i && (ppm_abs > UNLOCK_PPM);
  endsequence
  sequence s_restart;
    lock_lost_flag_o ##1 lock_lost_flag_o && (q_ff.digital_controlled_oscillator == '0);
  endsequence

  a_swing_default: assert property (@(posedge clk_i)
    $fell(rst_i) |-> data_swing_o == SWING_RST)
    else $error("data swing not at default after reset");
  a_clk_swing_def: assert property (@(posedge clk_i)
    $fell(rst_i) |-> clk_swing_o == SWING_RST)
    else $error("clock swing not at default after reset");
  a_swing_invalid_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_swing && (reg_wdata_i[7:4] < SWING_MIN_OK) |=> $stable(data_swing_o))
    else $error("invalid data swing code took effect");
  a_input_sel_one: assert property (@(posedge clk_i) disable iff (rst_i)
    input_sel_o != SEL_UNDEF)
    else $error("undefined input stage selected");
  a_eq_adapt_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(q_ff.eq_adp) |-> $past(reg_we_i) || $past(rate_fast && q_ff.adapt_eq))
    else $error("equalizer adapted while not allowed");
  a_lag_steer: assert property (@(posedge clk_i) disable iff (rst_i)
    late && (q_ff.st == CDR_TRACK) && (q_ff.digital_controlled_oscillator != dco_max) && !freq_vld_i
    |=> (q_ff.digital_controlled_oscillator == $past(q_ff.digital_controlled_oscillator) + 1'b1) && (q_ff.clock_phase_shifter == $past(q_ff.clock_phase_shifter) - 1'b1))
    else $error("lag did not raise frequency and shorten delay");
  a_dco_saturate: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_ff.st == CDR_TRACK) && (q_ff.digital_controlled_oscillator == dco_max) && late |=> q_ff.digital_controlled_oscillator == dco_max)
    else $error("oscillator word wrapped");
  a_psh_wrap: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_ff.clock_phase_shifter == '0) && late |=> q_ff.clock_phase_shifter == '1)
    else $error("phase shifter did not wrap");
  a_nodec_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !trans |=> $stable(q_ff.clock_phase_shifter))
    else $error("phase integrator moved without a decision");
  a_lock_acquire: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_ff.st == CDR_ACQ_MEAS) && freq_vld_i && (ppm_abs <= LOCK_PPM) |=> !lock_lost_flag_o)
    else $error("lock not declared within 250 ppm");
  a_lock_loss: assert property (@(posedge clk_i) disable iff (rst_i)
    s_unlock |=> s_restart)
    else $error("lock loss did not restart acquisition");
  a_fll_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (q_ff.st == CDR_TRACK) ##1 (q_ff.st == CDR_TRACK) |-> $stable(div_log2_o))
    else $error("division ratio moved while tracking");
endmodule : cdr_top
